// ===== test/link_status_control_bench.sv
// self-checking bench for the link status/control register pair
`timescale 1ns/1ps
module link_status_control_bench;
  import link_regs_pkg::*;
  localparam logic [3:0] IPM_TAB [3] = '{PWR_ACTIVE, PWR_PARTIAL, PWR_SLUMBER};
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 8'h00, dly = 8'h04;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, v;
  logic        wb_ack_o, comreset_o, pm_ack_o, pm_nak_o, go_partial_o, go_slumber_o;
  logic        cmd_list_enable_o, cominit, ready, offline, pm_req, pm_slp, phy_p, phy_s;
  logic        want_p = 0, want_s = 0, pres = 0, off = 0, req = 0, slp = 0, ce = 1;
  logic [1:0]  speed_limit_o, gen_dev, gen = 2'h3, pst = 2'h0;
  logic [31:0] exp_q[$], msk_q[$];
  int          err_count = 0, checks_done = 0, n;
  always #5 clk_i = ~clk_i;
  link_status_control dut (.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cominit_i(cominit),
    .phy_ready_i(ready), .phy_offline_i(offline), .phy_gen_i(gen_dev),
    .dev_pm_req_i(pm_req), .dev_pm_slumber_i(pm_slp), .phy_partial_i(phy_p),
    .phy_slumber_i(phy_s), .want_partial_i(want_p), .want_slumber_i(want_s), .comreset_o,
    .speed_limit_o, .pm_ack_o, .pm_nak_o, .go_partial_o, .go_slumber_o, .cmd_list_enable_o);
  sata_dev_model dev (.clk_i, .comreset_i(comreset_o), .present_i(pres), .off_i(off),
    .req_i(req), .slp_i(slp), .gen_i(gen), .lim_i(speed_limit_o), .pst_i(pst), .dly_i(dly),
    .cominit_o(cominit), .ready_o(ready), .offline_o(offline), .pm_req_o(pm_req),
    .pm_slumber_o(pm_slp), .partial_o(phy_p), .slumber_o(phy_s), .gen_o(gen_dev));
  task automatic chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one classic cycle; entered just after a rising edge, returns on one
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
    wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= s;
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) err_count++;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask
  // reset the link with a speed cap and wait for the drive to come up
  task automatic bring(input logic [3:0] cap, input logic [7:0] d);
    dly <= d;
    wb(1'b1, CONTROL_OFFSET, {24'h0, cap, DETC_INIT}, 4'h1);
    // hold shortened from a real millisecond: comreset_o is a level, so length is moot
    repeat (2) @(negedge clk_i);
    chk(comreset_o, 1'b1);
    chk(speed_limit_o, (cap == 4'h1 || cap == 4'h2) ? cap[1:0] : 2'h3);
    @(posedge clk_i);
    rd(STATUS_OFFSET, STATUS_RESET, '1);
    wb(1'b1, CONTROL_OFFSET, {24'h0, cap, DETC_IDLE}, 4'h1);
    @(negedge clk_i);
    chk(comreset_o, 1'b0);
    @(posedge clk_i);
    if (d > 8'd30) rd(STATUS_OFFSET, {28'h0, DET_PRESENT}, 32'hF);
    repeat (d + 24) @(posedge clk_i);
    rd(STATUS_OFFSET, {20'h0, PWR_ACTIVE, (cap == 4'h1 || cap == 4'h2) ? cap : SPD_GEN3,
       DET_COMM}, '1);
  endtask
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      chk(wb_dat_o & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    end_sim();
  end
  initial begin
    void'($urandom(97));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(CONTROL_OFFSET, CONTROL_RESET, '1);
    wb(1'b1, STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF);
    rd(STATUS_OFFSET, STATUS_RESET, '1);
    rd(8'h40, 32'h0, '1);
    pres <= 1'b1;
    for (int c = 0; c < 4; c++) bring(c[3:0], (c == 1) ? 8'd60 : 8'd4);
    foreach (IPM_TAB[i]) begin
      pst <= i[1:0];
      repeat (8) @(posedge clk_i);
      rd(STATUS_OFFSET, {20'h0, IPM_TAB[i], 8'h33}, '1);
    end
    // pins move while the clock enable is low: status must stay frozen
    pst <= 2'h0; off <= 1'b1; ce <= 1'b0;
    repeat (8) @(posedge clk_i);
    ce <= 1'b1;
    rd(STATUS_OFFSET, {20'h0, PWR_SLUMBER, 8'h33}, '1);
    repeat (8) @(posedge clk_i);
    rd(STATUS_OFFSET, {28'h0, DET_OFFLINE}, 32'hF);
    off <= 1'b0; want_p <= 1'b1; want_s <= 1'b1;
    for (int c = 0; c < 4; c++) for (int k = 0; k < 2; k++) begin
      wb(1'b1, CONTROL_OFFSET, {20'h0, c[3:0], 8'h00}, 4'h2);
      slp <= k[0]; req <= 1'b1;
      n = 0;
      do @(posedge clk_i); while (pm_ack_o !== 1'b1 && pm_nak_o !== 1'b1 && ++n < 40);
      @(negedge clk_i);
      chk(pm_nak_o, c[k]);
      chk(pm_ack_o, !c[k]);
      @(posedge clk_i);
      req <= 1'b0;
      repeat (8) @(negedge clk_i);
      chk({go_slumber_o, go_partial_o}, 2'(~c[1:0]));
      @(posedge clk_i);
    end
    for (int i = 0; i < 4; i++) begin
      v = $urandom & 32'hFFFF_FFF0;
      wb(1'b1, CONTROL_OFFSET, v, 4'hF);
      rd(CONTROL_OFFSET, v & 32'h0000_0FF0, '1);
    end
    wb(1'b1, PORT_CMD_OFFSET, 32'h1, 4'h1);
    @(negedge clk_i);
    chk(cmd_list_enable_o, 1'b1);
    @(posedge clk_i);
    end_sim();
  end
endmodule // link_status_control_bench
bind link_status_control link_status_control_checker chk_u (.*);

// ===== test/link_status_control_checker.sv
// checker: port-level assertions for the link register pair
`timescale 1ns/1ps
module link_status_control_checker
  import link_regs_pkg::*;
(
  input wire logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  input wire logic        wb_ack_o, comreset_o, pm_nak_o, cmd_list_enable_o,
  input wire logic [1:0]  speed_limit_o
);
  logic [31:0] shadow_reg;
  wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
  wire wr_c = take & wb_we_i & (wb_adr_i == CONTROL_OFFSET) & wb_sel_i[0];
  wire rd_s = take & ~wb_we_i & (wb_adr_i == STATUS_OFFSET);
  wire rd_c = take & ~wb_we_i & (wb_adr_i == CONTROL_OFFSET);
  wire rd_u = take & ~wb_we_i & !(wb_adr_i inside {STATUS_OFFSET, CONTROL_OFFSET, PORT_CMD_OFFSET});
  wire wr_p = take & wb_we_i & (wb_adr_i == PORT_CMD_OFFSET) & wb_sel_i[0];
  // only the writable fields are mirrored, so reserved bits stay zero here
  always_ff @(posedge clk_i) begin
    if (rst_i) shadow_reg <= CONTROL_RESET;
    else if (take & wb_we_i & (wb_adr_i == CONTROL_OFFSET)) begin
      if (wb_sel_i[0]) shadow_reg[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) shadow_reg[11:8] <= wb_dat_i[11:8];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next_cycle: assert property (take |=> wb_ack_o)
    else $error("ack missing");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ctl_read_back: assert property (rd_c |=> wb_dat_o == shadow_reg)
    else $error("control readback wrong");
  a_speed_cap_map: assert property (speed_limit_o ==
    ((shadow_reg[7:4] == 4'h1 || shadow_reg[7:4] == 4'h2) ? shadow_reg[5:4] : 2'h3))
    else $error("speed cap wrong");
  a_comreset_start: assert property (wr_c && wb_dat_i[3:0] == DETC_INIT |-> ##[1:3] comreset_o)
    else $error("comreset not started");
  a_comreset_cause: assert property (!$stable(comreset_o) |->
    $past(wr_c) || $past(wr_c, 2) || $past(rst_i)) else $error("comreset changed alone");
  a_status_zeroed: assert property (rd_s && comreset_o |=> wb_dat_o == STATUS_RESET)
    else $error("status not zero in comreset");
  a_status_codes: assert property (rd_s |=> wb_dat_o[31:12] == 20'h0 &&
    wb_dat_o[11:8] inside {4'h0, 4'h1, 4'h2, 4'h6} && wb_dat_o[7:4] <= 4'h3 &&
    wb_dat_o[3:0] inside {4'h0, 4'h1, 4'h3, 4'h4}) else $error("status code bad");
  a_unmapped_zero: assert property (rd_u |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_start_bit_set: assert property (wr_p |=> cmd_list_enable_o == $past(wb_dat_i[START_BIT]))
    else $error("start bit wrong");
  c_comreset: cover property (wr_c && wb_dat_i[3:0] == DETC_INIT);
  c_pm_refused: cover property (pm_nak_o);
  c_status_read: cover property (rd_s);
endmodule // link_status_control_checker

// ===== test/sata_dev_model.sv
// behavioural model of the drive across the serial link
`timescale 1ns/1ps
module sata_dev_model (
  input  wire logic       clk_i, comreset_i, present_i, off_i, req_i, slp_i,
  input  wire logic [1:0] gen_i, lim_i, pst_i,
  input  wire logic [7:0] dly_i,
  output logic            cominit_o, ready_o, offline_o, pm_req_o, pm_slumber_o,
  output logic            partial_o, slumber_o,
  output logic [1:0]      gen_o
);
  logic [7:0] cnt_reg = 8'h00;
  // the drive restarts its wake-up while reset is on the wire
  always @(posedge clk_i) begin
    if (comreset_i || !present_i) cnt_reg <= 8'h00;
    else if (cnt_reg != 8'hFF) cnt_reg <= cnt_reg + 8'h01;
  end
  assign cominit_o = present_i && cnt_reg > dly_i && cnt_reg <= dly_i + 8'h04;
  assign ready_o = present_i && cnt_reg > dly_i + 8'h08;
  assign gen_o = (gen_i > lim_i) ? lim_i : gen_i;
  assign offline_o = off_i;
  assign pm_req_o = req_i;
  assign pm_slumber_o = slp_i;
  assign partial_o = pst_i == 2'h1;
  assign slumber_o = pst_i == 2'h2;
endmodule // sata_dev_model

// ===== verilog/link_ctrl_if.sv
// interface: control fields and link pin states passed between the register bank and its helpers
`timescale 1ns/1ps
interface link_ctrl_if;
  logic [3:0] ipm_allow;
  logic [3:0] pm_req_state;
  logic       pm_req;
  logic       pm_ack;
  logic       pm_nak;
  logic       pm_go_partial;
  logic       pm_go_slumber;
  logic       pm_want_partial;
  logic       pm_want_slumber;

  modport bank (output ipm_allow, output pm_req_state, output pm_req,
                output pm_want_partial, output pm_want_slumber,
                input pm_ack, input pm_nak, input pm_go_partial, input pm_go_slumber);
  modport gate (input ipm_allow, input pm_req_state, input pm_req,
                input pm_want_partial, input pm_want_slumber,
                output pm_ack, output pm_nak, output pm_go_partial, output pm_go_slumber);
endinterface // link_ctrl_if

// ===== verilog/link_regs_pkg.sv
// package: offsets, field layouts, reset values and encodings of the link status/control pair
package link_regs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFFSET  = 8'h28;
  localparam logic [7:0] CONTROL_OFFSET = 8'h2C;
  localparam logic [7:0] PORT_CMD_OFFSET = 8'h18;
  localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DET_LSB   = 0;
  localparam int SPD_LSB   = 4;
  localparam int IPM_LSB   = 8;
  localparam int START_BIT = 0;

  // ----------------------------------------------------------------
  // status encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] DET_NONE      = 4'h0;
  localparam logic [3:0] DET_PRESENT   = 4'h1;
  localparam logic [3:0] DET_COMM      = 4'h3;
  localparam logic [3:0] DET_OFFLINE   = 4'h4;
  localparam logic [3:0] PWR_NONE      = 4'h0;
  localparam logic [3:0] PWR_ACTIVE    = 4'h1;
  localparam logic [3:0] PWR_PARTIAL   = 4'h2;
  localparam logic [3:0] PWR_SLUMBER   = 4'h6;
  localparam logic [3:0] SPD_NONE      = 4'h0;
  localparam logic [3:0] SPD_GEN3      = 4'h3;

  // ----------------------------------------------------------------
  // control encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] DETC_IDLE     = 4'h0;
  localparam logic [3:0] DETC_INIT     = 4'h1;
  localparam logic [3:0] IPMC_MAX      = 4'h3;
  localparam logic [3:0] SPDC_MAX      = 4'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 10;
  localparam int COMRESET_HOLD_MS    = 1;
  localparam int COMRESET_HOLD_CYCLES =
    (COMRESET_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    LS_IDLE    = 4'b0001,
    LS_RESET   = 4'b0010,
    LS_WAIT    = 4'b0100,
    LS_UP      = 4'b1000
  } link_state_t;

endpackage

// ===== verilog/link_status_control.sv
// top: serial link status and control register pair behind a classic Wishbone slave
// ----------------------------------------------------------------
// Notes on behaviour
// - status register tracks link state continuously
// - sending COMRESET zeroes the status register
// - bits 11:8 show interface power state
// - bits 7:4 show negotiated speed
// - bits 3:0 show detection and phy state
// - received COMINIT always shows device present; here offline shows 4h and an up link shows 3h
// - control reads return last written value
// - control writes start link actions
// - multiplier and pm select read zero
// - bits 11:8 disable partial/slumber transitions
// - disabled states never entered, requests refused
// - bits 7:4 cap speed negotiation
// - detection code 0h takes no action
// - detection code 1h performs hard reset
// - COMRESET sent while detection code is 1h
// - any standard COMRESET behaviour allowed
// - start bit permits command list processing
// ----------------------------------------------------------------
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module link_status_control
  import link_regs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // phy side (asynchronous pins)
  input  wire logic        cominit_i,
  input  wire logic        phy_ready_i,
  input  wire logic        phy_offline_i,
  input  wire logic [1:0]  phy_gen_i,
  input  wire logic        dev_pm_req_i,
  input  wire logic        dev_pm_slumber_i,
  input  wire logic        phy_partial_i,
  input  wire logic        phy_slumber_i,
  input  wire logic        want_partial_i,
  input  wire logic        want_slumber_i,
  output logic             comreset_o,
  output logic [1:0]       speed_limit_o,
  output logic             pm_ack_o,
  output logic             pm_nak_o,
  output logic             go_partial_o,
  output logic             go_slumber_o,
  output logic             cmd_list_enable_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 9;
  logic [NPIN-1:0] pin_raw, pin_syn;
  logic cominit_s, ready_s, offline_s, pmreq_s, pmslu_s, part_s, slu_s;
  logic [1:0] gen_s;

  assign pin_raw = {cominit_i, phy_ready_i, phy_offline_i, phy_gen_i,
                    dev_pm_req_i, dev_pm_slumber_i, phy_partial_i, phy_slumber_i};

  pin_sync3 #(.W(NPIN)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (pin_raw),
    .q_o   (pin_syn)
  );

  assign {cominit_s, ready_s, offline_s, gen_s, pmreq_s, pmslu_s, part_s, slu_s} = pin_syn;

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  logic        req, wr, hit_sts, hit_ctl, hit_cmd;
  logic        ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;

  assign req     = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr      = req && wb_we_i;
  assign hit_sts = (wb_adr_i == STATUS_OFFSET);
  assign hit_ctl = (wb_adr_i == CONTROL_OFFSET);
  assign hit_cmd = (wb_adr_i == PORT_CMD_OFFSET);

  // ----------------------------------------------------------------
  // control register and start bit
  // ----------------------------------------------------------------
  logic [11:0] ctl_reg, ctl_next;
  logic        start_reg, start_next;
  logic [3:0]  det_ctl, spd_ctl;

  always_comb begin
    ctl_next   = ctl_reg;
    start_next = start_reg;
    if (wr && hit_ctl) begin
      // bits 31:12 are not stored, so they stay zero
      if (wb_sel_i[0]) ctl_next[7:0]  = wb_dat_i[7:0];
      if (wb_sel_i[1]) ctl_next[11:8] = wb_dat_i[11:8];
    end
    if (wr && hit_cmd && wb_sel_i[0]) begin
      start_next = wb_dat_i[START_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg   <= CONTROL_RESET[11:0];
      start_reg <= 1'b0;
    end else if (ce_i) begin
      ctl_reg   <= ctl_next;
      start_reg <= start_next;
    end
  end

  assign det_ctl = ctl_reg[DET_LSB +: 4];
  assign spd_ctl = ctl_reg[SPD_LSB +: 4];
  assign cmd_list_enable_o = start_reg;

  // ----------------------------------------------------------------
  // link sequencer
  // ----------------------------------------------------------------
  link_state_t st_reg, st_next;
  logic        comreset;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      LS_IDLE: begin
        if (det_ctl == DETC_INIT) st_next = LS_RESET;
        else if (ready_s) st_next = LS_UP;
        else if (cominit_s) st_next = LS_WAIT;
      end
      LS_RESET: begin
        // COMRESET is held as a level for the whole time the field holds 1h
        if (det_ctl != DETC_INIT) st_next = LS_WAIT;
      end
      LS_WAIT: begin
        if (det_ctl == DETC_INIT) st_next = LS_RESET;
        else if (ready_s) st_next = LS_UP;
      end
      LS_UP: begin
        if (det_ctl == DETC_INIT) st_next = LS_RESET;
        else if (!ready_s) st_next = LS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) st_reg <= LS_IDLE;
    else if (ce_i) st_reg <= st_next;
  end

  assign comreset   = (st_reg == LS_RESET);
  assign comreset_o = comreset;

  // speed cap: reserved codes impose no limit
  always_comb begin
    if (spd_ctl == 4'h0 || spd_ctl > SPDC_MAX) speed_limit_o = 2'h3;
    else speed_limit_o = spd_ctl[1:0];
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  logic [11:0] sts_reg, sts_next;
  logic [3:0]  det_v, spd_v, ipm_v;

  always_comb begin
    det_v = DET_NONE;
    spd_v = SPD_NONE;
    ipm_v = PWR_NONE;
    if (offline_s) begin
      det_v = DET_OFFLINE;
    end else if (st_reg == LS_UP) begin
      det_v = DET_COMM;
      spd_v = (gen_s == 2'h0) ? 4'h1 : {2'b00, gen_s};
      ipm_v = slu_s ? PWR_SLUMBER : (part_s ? PWR_PARTIAL : PWR_ACTIVE);
    end else if (cominit_s || st_reg == LS_WAIT) begin
      det_v = DET_PRESENT;
    end
    sts_next = {ipm_v, spd_v, det_v};
    // cleared on the edge comreset_o rises, so no read sees stale fields then
    if (st_next == LS_RESET) sts_next = STATUS_RESET[11:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) sts_reg <= STATUS_RESET[11:0];
    else if (ce_i) sts_reg <= sts_next;
  end

  // ----------------------------------------------------------------
  // power-state gate
  // ----------------------------------------------------------------
  link_ctrl_if lc ();

  assign lc.ipm_allow       = ctl_reg[IPM_LSB +: 4];
  assign lc.pm_req          = pmreq_s && (st_reg == LS_UP);
  assign lc.pm_req_state    = pmslu_s ? PWR_SLUMBER : PWR_PARTIAL;
  assign lc.pm_want_partial = want_partial_i && (st_reg == LS_UP);
  assign lc.pm_want_slumber = want_slumber_i && (st_reg == LS_UP);

  pm_gate u_pm (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .lc    (lc)
  );

  assign pm_ack_o     = lc.pm_ack;
  assign pm_nak_o     = lc.pm_nak;
  assign go_partial_o = lc.pm_go_partial;
  assign go_slumber_o = lc.pm_go_slumber;

  // ----------------------------------------------------------------
  // read data and acknowledge
  // ----------------------------------------------------------------
  always_comb begin
    ack_next = req;
    dat_next = dat_reg;
    if (req && !wb_we_i) begin
      dat_next = 32'h0000_0000;
      if (hit_sts) dat_next = {20'h0_0000, sts_reg};
      if (hit_ctl) dat_next = {20'h0_0000, ctl_reg};
      if (hit_cmd) dat_next = {31'h0000_0000, start_reg};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

endmodule // link_status_control

// ===== verilog/pin_sync3.sv
// three-stage synchroniser: output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  logic [W-1:0] q_next;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        q_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : q_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end else if (ce_i) begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule // pin_sync3

// ===== verilog/pm_gate.sv
// power-state gate: blocks disallowed partial/slumber entries and answers device requests
`timescale 1ns/1ps
module pm_gate
  import link_regs_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   ce_i,
  link_ctrl_if.gate   lc
);
  logic partial_off, slumber_off, req_partial, req_slumber, refuse;
  logic ack_reg, nak_reg, ack_next, nak_next;

  always_comb begin
    // reserved allow codes fall back to no restriction
    partial_off = (lc.ipm_allow <= IPMC_MAX) && lc.ipm_allow[0];
    slumber_off = (lc.ipm_allow <= IPMC_MAX) && lc.ipm_allow[1];
    req_partial = lc.pm_req && (lc.pm_req_state == PWR_PARTIAL);
    req_slumber = lc.pm_req && (lc.pm_req_state == PWR_SLUMBER);
    refuse      = (req_partial && partial_off) || (req_slumber && slumber_off)
                  || (lc.pm_req && !req_partial && !req_slumber);
    nak_next    = lc.pm_req && refuse;
    ack_next    = lc.pm_req && !refuse;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      nak_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= ack_next;
      nak_reg <= nak_next;
    end
  end

  assign lc.pm_ack        = ack_reg;
  assign lc.pm_nak        = nak_reg;
  assign lc.pm_go_partial = lc.pm_want_partial && !partial_off;
  assign lc.pm_go_slumber = lc.pm_want_slumber && !slumber_off;
endmodule // pm_gate
